// ==== rtl/pdes_map.svh ====
`ifndef PDES_MAP_SVH
`define PDES_MAP_SVH

// register byte offsets
`define PDES_OFF_CTRL    8'h00
`define PDES_OFF_CMD     8'h04
`define PDES_OFF_PULSE   8'h08
`define PDES_OFF_SPEED   8'h0C
`define PDES_OFF_DECEL   8'h10
`define PDES_OFF_SLMP    8'h14
`define PDES_OFF_SLMM    8'h18
`define PDES_OFF_LPOS    8'h1C
`define PDES_OFF_ERR     8'h20
`define PDES_OFF_DSTAT   8'h24

// control register fields
`define PDES_CTRL_HWEN   0
`define PDES_CTRL_SLEN   1
`define PDES_CTRL_INST   2
`define PDES_CTRL_W      3
`define PDES_CTRL_RST    3'h1

// command codes
`define PDES_CMD_REL     8'h40
`define PDES_CMD_CREL    8'h41
`define PDES_CMD_ABS     8'h42
`define PDES_CMD_CLR     8'h79

// error bit positions
`define PDES_ERR_SLP     0
`define PDES_ERR_SLM     1
`define PDES_ERR_HLP     2
`define PDES_ERR_HLM     3
`define PDES_ERR_ALM     4
`define PDES_ERR_EMG     5
`define PDES_ERR_W       6

// synchronised input positions
`define PDES_IN_LP       0
`define PDES_IN_LM       1
`define PDES_IN_ALM      2
`define PDES_IN_EMG      3
`define PDES_IN_W        4

// drive status fields
`define PDES_DST_BUSY    0
`define PDES_DST_FIN     1
`define PDES_DST_DIR     2

// reset values and rate
`define PDES_SPEED_RST   32'h000003E8
`define PDES_DECEL_RST   32'h00000000
`define PDES_SLMP_RST    32'h7FFFFFFF
`define PDES_SLMM_RST    32'h80000000
`define PDES_CLK_HZ      32'h01312D00

`endif

// ==== rtl/pdes_pkg.sv ====
package pdes_pkg;

  typedef enum logic [2:0] {
    PDES_IDLE  = 3'b001,
    PDES_RUN   = 3'b010,
    PDES_DECEL = 3'b100
  } pdes_state_type;

  typedef struct packed {
    pdes_state_type st;
    logic           dir;
    logic           fin;
    logic           pulse;
    logic [31:0]    rem;
    logic [31:0]    pos;
    logic [31:0]    acc;
    logic [31:0]    cur_spd;
    logic [31:0]    spd;
    logic [31:0]    dec;
    logic [31:0]    pcount;
    logic [31:0]    slp;
    logic [31:0]    slm;
    logic [2:0]     ctrl;
    logic [5:0]     err;
    logic [3:0]     s1;
    logic [3:0]     s2;
    logic [3:0]     s3;
    logic [3:0]     in;
    logic [31:0]    rdata;
  } pdes_regs_type;

endpackage : pdes_pkg

// ==== rtl/pdes_top.sv ====
`timescale 1ns/1ns
`include "pdes_map.svh"
module pdes_top
  import pdes_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        plus_limit_input_i,
  input  wire logic        minus_limit_input_i,
  input  wire logic        alarm_i,
  input  wire logic        emg_stop_i,
  output logic             pulse_o,
  output logic             dir_o,
  output logic             busy_o
);

  pdes_regs_type q;
  pdes_regs_type d;

  logic        wr;
  logic        setup;
  logic        mapped;
  logic        clr;
  logic        start;
  logic        sdir;
  logic [31:0] srem;
  logic [31:0] diff;
  logic        dir_e;
  logic        hw_en;
  logic        sl_hit;
  logic        hw_hit;
  logic        hard_stop;
  logic [5:0]  cause;
  logic [32:0] acc_sum;
  logic        tick;
  logic        last;
  logic        active;

  always_comb begin
    case (paddr_i)
      `PDES_OFF_CTRL, `PDES_OFF_CMD, `PDES_OFF_PULSE, `PDES_OFF_SPEED,
      `PDES_OFF_DECEL, `PDES_OFF_SLMP, `PDES_OFF_SLMM, `PDES_OFF_LPOS,
      `PDES_OFF_ERR, `PDES_OFF_DSTAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign setup     = psel_i & ~penable_i;
  assign wr        = psel_i & penable_i & pwrite_i & mapped;
  assign pready_o  = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o  = q.rdata;
  assign pulse_o   = q.pulse;
  assign dir_o     = q.dir;
  assign busy_o    = (q.st != PDES_IDLE);

  always_comb begin
    d       = q;
    d.pulse = 1'b0;
    // three-stage sampling, a change counts once stages two and three agree
    d.s1 = {emg_stop_i, alarm_i, minus_limit_input_i, plus_limit_input_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.in = (q.s2 & q.s3) | (q.in & (q.s2 ^ q.s3));

    clr   = 1'b0;
    start = 1'b0;
    sdir  = q.dir;
    srem  = 32'h00000000;
    diff  = q.pcount - q.pos;
    if (wr) begin
      case (paddr_i)
        `PDES_OFF_CTRL:  d.ctrl = pwdata_i[`PDES_CTRL_W-1:0];
        `PDES_OFF_PULSE: d.pcount = pwdata_i;
        `PDES_OFF_SPEED: d.spd = pwdata_i;
        `PDES_OFF_DECEL: d.dec = pwdata_i;
        `PDES_OFF_SLMP:  d.slp = pwdata_i;
        `PDES_OFF_SLMM:  d.slm = pwdata_i;
        `PDES_OFF_LPOS:  d.pos = pwdata_i;
        `PDES_OFF_CMD: begin
          case (pwdata_i[7:0])
            `PDES_CMD_CLR: clr = 1'b1;
            `PDES_CMD_REL: begin
              start = 1'b1;
              sdir  = ~q.pcount[31];
              srem  = q.pcount[31] ? (32'h00000000 - q.pcount) : q.pcount;
            end
            `PDES_CMD_CREL: begin
              start = 1'b1;
              sdir  = 1'b0;
              srem  = q.pcount;
            end
            `PDES_CMD_ABS: begin
              start = 1'b1;
              sdir  = ~diff[31];
              srem  = diff[31] ? (32'h00000000 - diff) : diff;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // stop causes; limits seen in the direction that is or is about to be driven, alarm and emergency in either
    dir_e = start ? sdir : q.dir;
    hw_en = q.ctrl[`PDES_CTRL_HWEN];
    cause = 6'h00;
    cause[`PDES_ERR_SLP] = q.ctrl[`PDES_CTRL_SLEN] & dir_e
                           & ($signed(q.pos) >= $signed(q.slp));
    cause[`PDES_ERR_SLM] = q.ctrl[`PDES_CTRL_SLEN] & ~dir_e
                           & ($signed(q.pos) <= $signed(q.slm));
    cause[`PDES_ERR_HLP] = hw_en & dir_e & q.in[`PDES_IN_LP];
    cause[`PDES_ERR_HLM] = hw_en & ~dir_e & q.in[`PDES_IN_LM];
    cause[`PDES_ERR_ALM] = q.in[`PDES_IN_ALM];
    cause[`PDES_ERR_EMG] = q.in[`PDES_IN_EMG];
    sl_hit    = cause[`PDES_ERR_SLP] | cause[`PDES_ERR_SLM];
    hw_hit    = cause[`PDES_ERR_HLP] | cause[`PDES_ERR_HLM];
    hard_stop = hw_hit | cause[`PDES_ERR_ALM] | cause[`PDES_ERR_EMG]
                | (sl_hit & q.ctrl[`PDES_CTRL_INST]);

    // rate accumulator: one pulse each time the sum reaches or passes the clock rate
    active  = (q.st != PDES_IDLE);
    acc_sum = {1'b0, q.acc} + {1'b0, q.cur_spd};
    tick    = active & (acc_sum >= {1'b0, `PDES_CLK_HZ});
    last    = tick & (q.rem == 32'h00000001);

    // set wins over clear; terminating step sets nothing
    d.err = ((clr | start) ? 6'h00 : q.err)
            | ((start | (active & ~last)) ? cause : 6'h00);
    if (clr) begin
      d.fin = 1'b0;
    end

    if (start) begin
      d.dir     = sdir;
      d.rem     = srem;
      d.acc     = 32'h00000000;
      d.cur_spd = q.spd;
      if ((|cause) | (srem == 32'h00000000)) begin
        d.st  = PDES_IDLE;
        d.fin = 1'b1;
      end else begin
        d.st  = PDES_RUN;
        d.fin = 1'b0;
      end
    end else begin
      case (q.st)
        PDES_IDLE: ;
        PDES_RUN, PDES_DECEL: begin
          if (hard_stop & ~last) begin
            d.st  = PDES_IDLE;
            d.fin = 1'b1;
          end else begin
            if (sl_hit & (q.st == PDES_RUN)) begin
              d.st = PDES_DECEL;
            end
            d.acc = tick ? (acc_sum[31:0] - `PDES_CLK_HZ) : acc_sum[31:0];
            if (tick) begin
              d.pulse = 1'b1;
              d.pos   = q.dir ? (q.pos + 32'h00000001) : (q.pos - 32'h00000001);
              d.rem   = q.rem - 32'h00000001;
              if (q.st == PDES_DECEL) begin
                d.cur_spd = (q.cur_spd > q.dec) ? (q.cur_spd - q.dec) : 32'h00000000;
              end
              // zero decrement ends a decelerating stop at its first pulse
              if (last | ((q.st == PDES_DECEL)
                          & ((q.cur_spd <= q.dec) | (q.dec == 32'h00000000)))) begin
                d.st  = PDES_IDLE;
                d.fin = 1'b1;
              end
            end
          end
        end
        default: d.st = PDES_IDLE;
      endcase
    end

    // read data captured in the setup phase
    if (setup) begin
      case (paddr_i)
        `PDES_OFF_CTRL:  d.rdata = {29'h00000000, q.ctrl};
        `PDES_OFF_PULSE: d.rdata = q.pcount;
        `PDES_OFF_SPEED: d.rdata = q.spd;
        `PDES_OFF_DECEL: d.rdata = q.dec;
        `PDES_OFF_SLMP:  d.rdata = q.slp;
        `PDES_OFF_SLMM:  d.rdata = q.slm;
        `PDES_OFF_LPOS:  d.rdata = q.pos;
        `PDES_OFF_ERR:   d.rdata = {26'h0000000, q.err};
        `PDES_OFF_DSTAT: d.rdata = {29'h00000000, q.dir, q.fin, active};
        default:         d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q         <= '0;
      q.st      <= PDES_IDLE;
      q.dir     <= 1'b1;
      q.spd     <= `PDES_SPEED_RST;
      q.cur_spd <= `PDES_SPEED_RST;
      q.dec     <= `PDES_DECEL_RST;
      q.slp     <= `PDES_SLMP_RST;
      q.slm     <= `PDES_SLMM_RST;
      q.ctrl    <= `PDES_CTRL_RST;
    end else begin
      q <= d;
    end
  end

endmodule : pdes_top

// ==== verif/pdes_motor_model.sv ====
`timescale 1ns/1ns
module pdes_motor_model (
  input  wire logic        mclk_i,
  input  wire logic        pulse_i,
  input  wire logic        dir_i,
  output logic      [31:0] steps_o
);
  // net step count as the driver sees it
  logic [31:0] count = 32'h0;
  assign steps_o = count;
  always @(posedge mclk_i) begin
    if (pulse_i) begin
      count <= dir_i ? count + 32'h1 : count - 32'h1;
    end
  end
endmodule : pdes_motor_model

// ==== verif/pdes_top_asserts.sv ====
`timescale 1ns/1ns
`include "pdes_map.svh"
module pdes_top_asserts (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        emg_stop_i,
  input wire logic        pulse_o,
  input wire logic        dir_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire acc  = psel_i && penable_i;
  wire cmdw = acc && pwrite_i && paddr_i == `PDES_OFF_CMD;
  a_ready_access: assert property (acc |-> pready_o)
    else $error("no ready");
  a_ready_idle: assert property (!acc |-> !pready_o)
    else $error("stray ready");
  a_slverr_hole: assert property (acc && paddr_i > 8'h24 |-> pslverr_o)
    else $error("no slave error");
  a_slverr_map: assert property (
    acc && paddr_i[1:0] == 2'h0 && paddr_i < 8'h28 |-> !pslverr_o) else $error("bad slverr");
  a_rdata_hold: assert property (!$past(psel_i && !penable_i) |-> $stable(prdata_o))
    else $error("read data moved");
  a_pulse_single: assert property (pulse_o |=> !pulse_o)
    else $error("long pulse");
  a_pulse_driving: assert property (pulse_o |-> $past(busy_o))
    else $error("pulse while idle");
  a_emg_halt: assert property (emg_stop_i [*8] |-> !pulse_o)
    else $error("pulse in emergency");
  a_dir_steady: assert property (
    busy_o && $past(busy_o) && !$past(cmdw) && !$past(cmdw, 2) |-> $stable(dir_o))
    else $error("dir moved in drive");
endmodule : pdes_top_asserts

bind pdes_top pdes_top_asserts u_pdes_top_asserts (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .emg_stop_i(emg_stop_i), .pulse_o(pulse_o), .dir_o(dir_o),
  .busy_o(busy_o)
);

// ==== verif/pdes_top_test.sv ====
`timescale 1ns/1ns
`include "pdes_map.svh"
module pdes_top_test;
  logic        mclk_i   = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel_i   = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i  = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  cause    = 4'h0;
  logic [31:0] prdata_o, rd, p0, s0, steps;
  logic        pready_o, pslverr_o, pulse_o, dir_o, busy_o, se;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc;
  always #25 mclk_i = ~mclk_i;
  pdes_top u_pdes_top (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .plus_limit_input_i(cause[0]), .minus_limit_input_i(cause[1]), .alarm_i(cause[2]),
    .emg_stop_i(cause[3]), .pulse_o(pulse_o), .dir_o(dir_o), .busy_o(busy_o));
  pdes_motor_model u_pdes_motor_model (.mclk_i(mclk_i), .pulse_i(pulse_o), .dir_i(dir_o),
    .steps_o(steps));
  task automatic close_out;
    $display("compared %0d, wrong %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic step(input int lim);
    @(posedge mclk_i);
    cyc++;
    if (cyc > lim) begin
      err_total++;
      close_out;
    end
  endtask : step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    cyc = 0;
    do step(50); while (pready_o !== 1'b1);
    rd = prdata_o;
    se = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdchk
  task automatic drive(input logic [7:0] c, input logic [31:0] n);
    s0 = steps;
    apb(1'b1, `PDES_OFF_PULSE, n);
    apb(1'b1, `PDES_OFF_CMD, {24'h0, c});
  endtask : drive
  task automatic settle;
    cyc = 0;
    step(2000);
    while (busy_o !== 1'b0) step(2000);
    // let the model count the final pulse
    @(posedge mclk_i);
  endtask : settle
  task automatic run(input logic [7:0] c, input logic [31:0] n);
    drive(c, n);
    settle;
  endtask : run
  task automatic t_moves;
    rdchk("ctrl", `PDES_OFF_CTRL, 32'h1);
    rdchk("slmm", `PDES_OFF_SLMM, 32'h80000000);
    rdchk("hole", 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    apb(1'b1, `PDES_OFF_SPEED, 32'h00989680);
    run(`PDES_CMD_REL, 32'h4);
    chk("rate", 32'h1, {31'h0, cyc < 20});
    chk("rel_plus", 32'h4, steps - s0);
    run(`PDES_CMD_REL, 32'hFFFFFFFE);
    chk("rel_minus", 32'hFFFFFFFE, steps - s0);
    run(`PDES_CMD_CREL, 32'h3);
    chk("crel", 32'hFFFFFFFD, steps - s0);
    apb(1'b0, `PDES_OFF_LPOS, 32'h0);
    p0 = rd;
    run(`PDES_CMD_ABS, 32'h5);
    chk("abs_steps", 32'h5 - p0, steps - s0);
    rdchk("abs_pos", `PDES_OFF_LPOS, 32'h5);
    $display("moves done");
  endtask : t_moves
  task automatic t_faults;
    drive(`PDES_CMD_REL, 32'h64);
    repeat (20) @(posedge mclk_i);
    cause <= 4'h8;
    run(`PDES_CMD_REL, 32'h64);
    repeat (60) @(posedge mclk_i);
    cause <= 4'h0;
    repeat (8) @(posedge mclk_i);
    rdchk("err_kept", `PDES_OFF_ERR, 32'h20);
    run(`PDES_CMD_REL, 32'h1);
    rdchk("err_start", `PDES_OFF_ERR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      cause <= 4'h1 << i;
      repeat (8) @(posedge mclk_i);
      run(i == 1 ? `PDES_CMD_CREL : `PDES_CMD_REL, 32'h2);
      chk("held", 32'h0, steps - s0);
      rdchk("err_bit", `PDES_OFF_ERR, 32'h4 << i);
    end
    cause <= 4'h0;
    apb(1'b1, `PDES_OFF_CMD, 32'h79);
    rdchk("err_clr", `PDES_OFF_ERR, 32'h0);
    apb(1'b1, `PDES_OFF_CTRL, 32'h0);
    cause <= 4'h1;
    repeat (8) @(posedge mclk_i);
    run(`PDES_CMD_REL, 32'h3);
    chk("hw_off", 32'h3, steps - s0);
    rdchk("hw_off_err", `PDES_OFF_ERR, 32'h0);
    $display("faults done");
  endtask : t_faults
  task automatic t_soft;
    // emergency reaches the core exactly on the terminating pulse
    apb(1'b1, `PDES_OFF_PULSE, 32'h1);
    s0 = steps;
    cause <= 4'h8;
    @(posedge mclk_i);
    apb(1'b1, `PDES_OFF_CMD, {24'h0, `PDES_CMD_REL});
    settle;
    chk("term_steps", 32'h1, steps - s0);
    rdchk("term_err", `PDES_OFF_ERR, 32'h0);
    cause <= 4'h0;
    repeat (8) @(posedge mclk_i);
    apb(1'b1, `PDES_OFF_CTRL, 32'h6);
    apb(1'b1, `PDES_OFF_SLMP, 32'h3);
    apb(1'b1, `PDES_OFF_LPOS, 32'h0);
    run(`PDES_CMD_REL, 32'hA);
    chk("soft_inst", 32'h3, steps - s0);
    rdchk("soft_err", `PDES_OFF_ERR, 32'h1);
    apb(1'b1, `PDES_OFF_CTRL, 32'h2);
    apb(1'b1, `PDES_OFF_LPOS, 32'h0);
    run(`PDES_CMD_REL, 32'hA);
    chk("soft_decel", 32'h4, steps - s0);
    rdchk("dstat", `PDES_OFF_DSTAT, 32'h6);
    $display("soft limit done");
  endtask : t_soft
  initial begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    t_moves;
    t_faults;
    t_soft;
    close_out;
  end
endmodule : pdes_top_test
